// ===== boot_mem_model.sv
// behavioural boot memory beside the control table loader
// assumes one request at a time, held until the acknowledge edge
`timescale 1ns/10ps
module boot_mem_model (
  input wire logic i_clk, // core clock
  input wire logic i_rst_n, // async reset, active low
  input wire ctl_loader_pkg::mem_req_type i_mem, // request from loader
  input wire logic [3:0] i_delay, // wait cycles before ack
  output logic o_ack, // one-cycle completion
  output logic [31:0] o_rdata // read data, valid with ack only
);
  // -------------------------------------------------------------
  // storage and access log
  // -------------------------------------------------------------
  logic [31:0] mem [logic [31:0]]; // sparse image; the bench fills it before boot and changes it later, write requests update it
  logic [31:0] rd_log [$];
  logic [3:0] wait_cnt;

  // data lines toggle outside ack so a stale word never looks valid
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack <= 1'b0;
      wait_cnt <= 4'h0;
      o_rdata <= 32'hFFFFFFFF;
    end else if (o_ack) begin
      o_ack <= 1'b0;
      wait_cnt <= 4'h0;
      o_rdata <= ~o_rdata;
      if (i_mem.rd) rd_log.push_back(i_mem.addr);
      if (i_mem.wr) mem[i_mem.addr] = i_mem.wdata; // writable table
    end else if ((i_mem.rd || i_mem.wr) && wait_cnt >= i_delay) begin
      o_ack <= 1'b1;
      o_rdata <= mem.exists(i_mem.addr) ? mem[i_mem.addr] : ~i_mem.addr;
    end else begin
      if (i_mem.rd || i_mem.wr) wait_cnt <= wait_cnt + 4'h1;
      o_rdata <= ~o_rdata;
    end
  end
endmodule

// ===== control_table_init_loader.sv
// control table loader: fetches process control block and control table words
// from boot memory after reset or reinitialization, then releases the core.
// assumes memory, core and register port all run on i_clk.
`timescale 1ns/10ps
`include "ctl_loader_params.svh"

module control_table_init_loader (
  input wire logic i_clk, // core clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [31:0] i_boot_ip, // first instruction pointer
  input wire logic [31:0] i_boot_prcb, // first control block pointer
  input wire logic i_reinit, // reinitialize message pulse
  input wire logic [31:0] i_reinit_ip, // reinit instruction pointer
  input wire logic [31:0] i_reinit_prcb, // reinit control block pointer
  input wire logic i_post_req, // software interrupt post pulse
  input wire logic [31:0] i_post_prio, // pending priority word
  input wire logic [31:0] i_post_irq, // pending interrupt word
  output ctl_loader_pkg::mem_req_type o_mem, // boot memory request
  input wire logic i_mem_ack, // memory completes request
  input wire logic [31:0] i_mem_rdata, // memory read data
  output logic o_core_hold, // core held while loading
  output logic o_fetch_start, // first fetch pulse
  output logic [31:0] o_fetch_ip, // first fetch address
  output logic o_gr0_we, // general register zero write
  output logic [31:0] o_gr0_data, // general register zero data
  output logic o_post_busy, // interrupt post in progress
  input wire logic [7:0] i_reg_addr, // register byte address
  input wire logic [31:0] i_reg_wdata, // register write data
  input wire logic i_reg_wr, // register write strobe
  input wire logic i_reg_rd, // register read strobe
  output logic [31:0] o_reg_rdata // read data, cycle after strobe
);

  // -------------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------------
  localparam logic [31:0] PART_ID = {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1};

  function automatic logic [7:0] prcb_off(input logic [4:0] step);
    case (step[1:0])
      2'h0: prcb_off = `PRCB_FAULT_OFF;
      2'h1: prcb_off = `PRCB_CTRL_OFF;
      2'h2: prcb_off = `PRCB_INT_OFF;
      default: prcb_off = `PRCB_SYSPROC_OFF;
    endcase
  endfunction

  // reserved words are never read, so their content cannot matter here
  function automatic logic [7:0] tbl_off(input logic [4:0] idx);
    case (idx)
      5'h00: tbl_off = `TBL_INT_MAP0_OFF;
      5'h01: tbl_off = `TBL_INT_MAP1_OFF;
      5'h02: tbl_off = `TBL_INT_MAP2_OFF;
      5'h03: tbl_off = `TBL_ICFG_OFF;
      5'h0C: tbl_off = `TBL_TRACE_OFF;
      5'h0D: tbl_off = `TBL_BUSCFG_OFF;
      default: tbl_off = `TBL_REGION_FIRST + 8'(idx - 5'h04) * `TBL_REGION_STRIDE;
    endcase
  endfunction

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  ctl_loader_pkg::state_type state_reg, state_next;
  ctl_loader_pkg::mem_req_type mem_reg, mem_next;
  logic [4:0] step_reg, step_next;
  logic [31:0] ptr_reg [`NUM_PTR_WORDS];
  logic [31:0] ptr_next [`NUM_PTR_WORDS];
  logic [31:0] ctl_reg [`NUM_CTL_WORDS];
  logic [31:0] ctl_next [`NUM_CTL_WORDS];
  logic [31:0] prcb_reg, prcb_next;
  logic [31:0] ip_reg, ip_next;
  logic [31:0] sw_ip_reg, sw_ip_next;
  logic [31:0] sw_prcb_reg, sw_prcb_next;
  logic sw_reinit_reg, sw_reinit_next;
  logic [31:0] prio_reg, prio_next;
  logic [31:0] irq_reg, irq_next;
  logic gr0_we_reg, gr0_we_next;
  logic [31:0] gr0_data_reg, gr0_data_next;
  logic fetch_reg, fetch_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] fetch_addr;
  logic [4:0] tbl_idx;
  logic [5:0] reg_word;

  assign tbl_idx = step_reg - 5'h04;
  assign reg_word = 6'((i_reg_addr - `REG_CTL_BASE) >> 2);
  assign fetch_addr = (step_reg <= `LAST_PRCB_STEP) ?
                      prcb_reg + {24'h000000, prcb_off(step_reg)} :
                      ptr_reg[`PTR_CTRL_IDX] + {24'h000000, tbl_off(tbl_idx)};

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    mem_next = mem_reg;
    step_next = step_reg;
    ptr_next = ptr_reg;
    ctl_next = ctl_reg;
    prcb_next = prcb_reg;
    ip_next = ip_reg;
    sw_ip_next = sw_ip_reg;
    sw_prcb_next = sw_prcb_reg;
    sw_reinit_next = sw_reinit_reg;
    prio_next = prio_reg;
    irq_next = irq_reg;
    gr0_we_next = 1'b0;
    gr0_data_next = gr0_data_reg;
    fetch_next = 1'b0;
    rdata_next = 32'h00000000;
    case (state_reg)
      ctl_loader_pkg::ST_IDLE: begin
        // boot pointers caught on the first edge after release
        prcb_next = i_boot_prcb;
        ip_next = i_boot_ip;
        step_next = 5'h00;
        state_next = ctl_loader_pkg::ST_PRCB;
      end
      ctl_loader_pkg::ST_PRCB, ctl_loader_pkg::ST_TABLE: begin
        if (!mem_reg.rd) begin
          mem_next.rd = 1'b1;
          mem_next.addr = fetch_addr;
        end else if (i_mem_ack) begin
          mem_next.rd = 1'b0;
          if (step_reg <= `LAST_PRCB_STEP) begin
            // pointers only change inside this flow
            ptr_next[step_reg[1:0]] = i_mem_rdata;
          end else begin
            ctl_next[tbl_idx[3:0]] = i_mem_rdata;
          end
          if (step_reg == `LAST_LOAD_STEP) begin
            // regions are in place; mark the loaded set valid
            ctl_next[`CTL_BUSCFG_IDX][`TABLE_VALID_BIT] = 1'b1;
            gr0_we_next = 1'b1;
            gr0_data_next = PART_ID;
            state_next = ctl_loader_pkg::ST_GR0;
          end else begin
            step_next = step_reg + 5'h01;
            if (step_reg == `LAST_PRCB_STEP) begin
              state_next = ctl_loader_pkg::ST_TABLE;
            end
          end
        end
      end
      ctl_loader_pkg::ST_GR0: begin
        fetch_next = 1'b1;
        state_next = ctl_loader_pkg::ST_RUN;
      end
      ctl_loader_pkg::ST_RUN: begin
        if (i_reinit) begin
          prcb_next = i_reinit_prcb;
          ip_next = i_reinit_ip;
          step_next = 5'h00;
          ctl_next[`CTL_BUSCFG_IDX][`TABLE_VALID_BIT] = 1'b0;
          state_next = ctl_loader_pkg::ST_PRCB;
        end else if (sw_reinit_reg) begin
          prcb_next = sw_prcb_reg;
          ip_next = sw_ip_reg;
          sw_reinit_next = 1'b0;
          step_next = 5'h00;
          ctl_next[`CTL_BUSCFG_IDX][`TABLE_VALID_BIT] = 1'b0;
          state_next = ctl_loader_pkg::ST_PRCB;
        end else if (i_post_req) begin
          prio_next = i_post_prio;
          irq_next = i_post_irq;
          step_next = 5'h00;
          state_next = ctl_loader_pkg::ST_POST;
        end
      end
      ctl_loader_pkg::ST_POST: begin
        if (!mem_reg.wr) begin
          mem_next.wr = 1'b1;
          mem_next.addr = ptr_reg[`PTR_INT_IDX] +
                          (step_reg[0] ? `INT_PEND_IRQ_OFF : `INT_PEND_PRIO_OFF);
          mem_next.wdata = step_reg[0] ? irq_reg : prio_reg;
        end else if (i_mem_ack) begin
          mem_next.wr = 1'b0;
          if (step_reg[0]) begin
            state_next = ctl_loader_pkg::ST_RUN;
          end else begin
            step_next = 5'h01;
          end
        end
      end
      default: begin
        state_next = ctl_loader_pkg::ST_IDLE;
      end
    endcase
    // register port writes; a write arriving as the request is taken keeps it pending
    if (i_reg_wr) begin
      case (i_reg_addr)
        `REG_CONTROL: begin
          if (i_reg_wdata[0]) begin
            sw_reinit_next = 1'b1;
          end
        end
        `REG_SW_IP: begin
          sw_ip_next = i_reg_wdata;
        end
        `REG_SW_PRCB: begin
          sw_prcb_next = i_reg_wdata;
        end
        default: begin
        end
      endcase
    end
    if (i_reg_rd) begin
      if (i_reg_addr >= `REG_CTL_BASE && i_reg_addr <= `REG_CTL_LAST &&
          i_reg_addr[1:0] == 2'h0) begin
        rdata_next = ctl_reg[reg_word[3:0]];
      end else if (i_reg_addr >= `REG_PTR_BASE && i_reg_addr < `REG_PTR_BASE + 8'h10 &&
                   i_reg_addr[1:0] == 2'h0) begin
        rdata_next = ptr_reg[i_reg_addr[3:2]];
      end else begin
        case (i_reg_addr)
          `REG_PART_ID: rdata_next = PART_ID;
          `REG_STATUS: rdata_next = {28'h0000000, sw_reinit_reg,
                                     ctl_reg[`CTL_BUSCFG_IDX][`TABLE_VALID_BIT],
                                     state_reg == ctl_loader_pkg::ST_POST,
                                     state_reg == ctl_loader_pkg::ST_RUN};
          `REG_CONTROL: rdata_next = {31'h00000000, sw_reinit_reg};
          `REG_SW_IP: rdata_next = sw_ip_reg;
          `REG_SW_PRCB: rdata_next = sw_prcb_reg;
          default: rdata_next = 32'h00000000;
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ctl_loader_pkg::ST_IDLE;
      mem_reg <= '0;
      step_reg <= 5'h00;
      ptr_reg <= '{default: `REG_RESET_VAL};
      ctl_reg <= '{default: `REG_RESET_VAL};
      prcb_reg <= `REG_RESET_VAL;
      ip_reg <= `REG_RESET_VAL;
      sw_ip_reg <= `REG_RESET_VAL;
      sw_prcb_reg <= `REG_RESET_VAL;
      sw_reinit_reg <= 1'b0;
      prio_reg <= `REG_RESET_VAL;
      irq_reg <= `REG_RESET_VAL;
      gr0_we_reg <= 1'b0;
      gr0_data_reg <= `REG_RESET_VAL;
      fetch_reg <= 1'b0;
      rdata_reg <= `REG_RESET_VAL;
    end else begin
      state_reg <= state_next;
      mem_reg <= mem_next;
      step_reg <= step_next;
      ptr_reg <= ptr_next;
      ctl_reg <= ctl_next;
      prcb_reg <= prcb_next;
      ip_reg <= ip_next;
      sw_ip_reg <= sw_ip_next;
      sw_prcb_reg <= sw_prcb_next;
      sw_reinit_reg <= sw_reinit_next;
      prio_reg <= prio_next;
      irq_reg <= irq_next;
      gr0_we_reg <= gr0_we_next;
      gr0_data_reg <= gr0_data_next;
      fetch_reg <= fetch_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_mem = mem_reg;
  assign o_core_hold = (state_reg != ctl_loader_pkg::ST_RUN) &&
                       (state_reg != ctl_loader_pkg::ST_POST);
  assign o_fetch_start = fetch_reg;
  assign o_fetch_ip = ip_reg;
  assign o_gr0_we = gr0_we_reg;
  assign o_gr0_data = gr0_data_reg;
  assign o_post_busy = (state_reg == ctl_loader_pkg::ST_POST);
  assign o_reg_rdata = rdata_reg;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  boot_starts_fetch_a: assert property (
    state_reg == ctl_loader_pkg::ST_IDLE |=> ##1 o_mem.rd && o_mem.addr == $past(i_boot_prcb, 2))
    else $error("boot fetch did not start at control block");
  imap_offsets_a: assert property (
    o_mem.rd && step_reg == 5'h04 |-> o_mem.addr == ptr_reg[`PTR_CTRL_IDX] + 32'h10)
    else $error("first interrupt map word at wrong offset");
  region_offsets_a: assert property (
    o_mem.rd && step_reg == 5'h0F |-> o_mem.addr == ptr_reg[`PTR_CTRL_IDX] + 32'h58)
    else $error("last region word at wrong offset");
  bus_cfg_last_a: assert property (
    o_mem.rd && step_reg == 5'h11 |-> o_mem.addr == ptr_reg[`PTR_CTRL_IDX] + 32'h6C)
    else $error("bus config word at wrong offset");
  gr0_before_fetch_a: assert property (
    o_gr0_we |-> o_gr0_data == PART_ID && o_gr0_data[0] ##1 o_fetch_start)
    else $error("identifier not written before first fetch");
  reinit_restart_a: assert property (
    state_reg == ctl_loader_pkg::ST_RUN && i_reinit |=>
      state_reg == ctl_loader_pkg::ST_PRCB && step_reg == 5'h00 ##1
      o_mem.rd && o_mem.addr == $past(i_reinit_prcb, 2))
    else $error("reinit did not restart at new control block");
  pointers_cached_a: assert property (
    state_reg == ctl_loader_pkg::ST_RUN && $past(state_reg) == ctl_loader_pkg::ST_RUN
      |-> $stable(ptr_reg[`PTR_CTRL_IDX]) && $stable(ptr_reg[`PTR_INT_IDX]))
    else $error("cached pointer changed outside reinit");
  post_write_a: assert property (
    o_mem.wr && step_reg == 5'h00 |-> o_mem.addr == ptr_reg[`PTR_INT_IDX] && o_mem.wdata == prio_reg)
    else $error("pending priority write misdirected");
  valid_at_fetch_a: assert property (
    o_fetch_start |-> ctl_reg[`CTL_BUSCFG_IDX][`TABLE_VALID_BIT] && !o_core_hold)
    else $error("table valid flag clear at first fetch");
  hold_while_load_a: assert property (
    o_mem.rd |-> o_core_hold && !o_fetch_start)
    else $error("core released during table load");

  cold_done_c: cover property (o_gr0_we ##1 o_fetch_start);
  reinit_c: cover property (state_reg == ctl_loader_pkg::ST_RUN && i_reinit);
  sw_reinit_c: cover property (state_reg == ctl_loader_pkg::ST_RUN && sw_reinit_reg && !i_reinit);
  post_c: cover property (o_mem.wr && step_reg == 5'h01 && i_mem_ack);

endmodule

// ===== control_table_init_loader_tb_top.sv
// testbench for the control table loader: boot, reinit paths, register port
// assumes boot memory model answers at a delay the bench selects
`timescale 1ns/10ps
`include "ctl_loader_params.svh"
module control_table_init_loader_tb_top;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [31:0] i_boot_ip = 32'h00000100;
  logic [31:0] i_boot_prcb = 32'h00001000;
  logic i_reinit = 1'b0, i_post_req = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [31:0] i_reinit_ip = 32'h0, i_reinit_prcb = 32'h0, i_post_prio = 32'h0;
  logic [31:0] i_post_irq = 32'h0, i_reg_wdata = 32'h0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [3:0] delay = 4'h0;
  ctl_loader_pkg::mem_req_type o_mem;
  logic i_mem_ack, o_core_hold, o_fetch_start, o_gr0_we, o_post_busy;
  logic [31:0] i_mem_rdata, o_fetch_ip, o_gr0_data, o_reg_rdata, rd;
  logic [31:0] part_id = {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1};
  int num_errors = 0;
  int num_checks = 0;

  always #5 i_clk = ~i_clk;

  control_table_init_loader DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_boot_ip(i_boot_ip),
    .i_boot_prcb(i_boot_prcb), .i_reinit(i_reinit), .i_reinit_ip(i_reinit_ip),
    .i_reinit_prcb(i_reinit_prcb), .i_post_req(i_post_req), .i_post_prio(i_post_prio),
    .i_post_irq(i_post_irq), .o_mem(o_mem), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
    .o_core_hold(o_core_hold), .o_fetch_start(o_fetch_start), .o_fetch_ip(o_fetch_ip),
    .o_gr0_we(o_gr0_we), .o_gr0_data(o_gr0_data), .o_post_busy(o_post_busy),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));

  boot_mem_model mem_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_mem(o_mem), .i_delay(delay),
    .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  function automatic logic [7:0] ctl_off(input int k);
    if (k < 4) return 8'h10 + 8'(4 * k);
    if (k < 12) return 8'h20 + 8'(8 * (k - 4));
    return (k == 12) ? 8'h68 : 8'h6C;
  endfunction

  function automatic logic [7:0] ptr_off(input int k);
    return (k < 2) ? 8'(4 * k) : 8'h10 + 8'(4 * (k - 2));
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask

  // reserved words zero, data words tagged by table and offset
  task automatic fill(input logic [31:0] prcb, ctrl, intb, input logic [15:0] seed);
    logic [31:0] word;
    for (int o = 0; o <= 'h6C; o += 4) mem_model.mem[ctrl + o] = 32'h0;
    for (int k = 0; k < 14; k++) mem_model.mem[ctrl + ctl_off(k)] = {seed, 8'h00, ctl_off(k)};
    for (int k = 4; k < 12; k++) begin
      // width code 2 (32-bit) at bit 22; bit 31 clear keeps the boot pair little endian
      word = mem_model.mem[ctrl + ctl_off(k)] & 32'h7F3FFFFF;
      mem_model.mem[ctrl + ctl_off(k)] = word | 32'h00800000;
    end
    mem_model.mem[prcb] = prcb + 32'h00000800;
    mem_model.mem[prcb + 4] = ctrl;
    mem_model.mem[prcb + 32'h10] = intb;
    mem_model.mem[prcb + 32'h14] = prcb + 32'h00000900;
  endtask

  // gr0 pulse, then first fetch one cycle later with hold released
  task automatic wait_boot(input logic [31:0] ip);
    for (int n = 0; n < 3000 && o_gr0_we !== 1'b1; n++) @(posedge i_clk) #1;
    check("gr0_we", 32'h1, {31'h0, o_gr0_we});
    check("gr0_data", part_id, o_gr0_data);
    check("hold_before_fetch", 32'h1, {31'h0, o_core_hold});
    @(posedge i_clk) #1;
    check("fetch_start", 32'h1, {31'h0, o_fetch_start});
    check("fetch_ip", ip, o_fetch_ip);
    check("hold_after_fetch", 32'h0, {31'h0, o_core_hold});
  endtask

  // read order, cached pointers and loaded words with valid flag forced
  task automatic check_load(input logic [31:0] prcb, ctrl);
    logic [31:0] exp;
    check("read_count", 32'd18, 32'(mem_model.rd_log.size()));
    for (int k = 0; k < 18; k++) begin
      exp = (k < 4) ? prcb + ptr_off(k) : ctrl + ctl_off(k - 4);
      if (k < mem_model.rd_log.size()) check("read_addr", exp, mem_model.rd_log[k]);
    end
    mem_model.rd_log.delete();
    for (int k = 0; k < 4; k++) begin
      reg_rd(`REG_PTR_BASE + 8'(4 * k), rd);
      check("cached_ptr", mem_model.mem[prcb + ptr_off(k)], rd);
    end
    for (int k = 0; k < 14; k++) begin
      exp = mem_model.mem[ctrl + ctl_off(k)] | ((k == 13) ? 32'h1 : 32'h0);
      reg_rd(`REG_CTL_BASE + 8'(4 * k), rd);
      check("loaded_word", exp, rd);
    end
    reg_rd(`REG_STATUS, rd);
    check("status_run_valid", 32'h5, rd);
  endtask

  task automatic conclude;
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    conclude();
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    fill(32'h1000, 32'h3000, 32'h4000, 16'hA1C0);
    fill(32'h6000, 32'h7000, 32'h4800, 16'hB2D0);
    mem_model.mem[32'h6004] = 32'h3000;
    repeat (8) @(posedge i_clk);
    check("reset_hold", 32'h1, {31'h0, o_core_hold});
    check("reset_mem_rd", 32'h0, {31'h0, o_mem.rd});
    i_rst_n <= 1'b1;
    wait_boot(32'h100);
    check_load(32'h1000, 32'h3000);
    reg_rd(`REG_PART_ID, rd);
    check("part_id", part_id, rd);
    check("id_marker_bit", 32'h1, rd & 32'h1);
    @(posedge i_clk) #1;
    check("rdata_after", 32'h0, o_reg_rdata);
    reg_wr(`REG_PART_ID, 32'h0);
    reg_wr(8'hF0, 32'hFFFFFFFF);
    reg_rd(`REG_PART_ID, rd);
    check("part_id_ro", part_id, rd);
    reg_rd(8'hF0, rd);
    check("unmapped", 32'h0, rd);
    // relocated table pointer only lands through reinit
    mem_model.mem[32'h1004] = 32'h7000;
    reg_rd(`REG_PTR_BASE + 8'h04, rd);
    check("ptr_unchanged", 32'h3000, rd);
    delay <= 4'h3;
    @(posedge i_clk);
    i_reinit_ip <= 32'h8000;
    i_reinit_prcb <= 32'h1000;
    i_reinit <= 1'b1;
    @(posedge i_clk);
    i_reinit <= 1'b0;
    #1 check("reinit_hold", 32'h1, {31'h0, o_core_hold});
    reg_rd(`REG_STATUS, rd);
    check("valid_cleared", 32'h0, rd & 32'h4);
    wait_boot(32'h8000);
    check_load(32'h1000, 32'h7000);
    delay <= 4'h0;
    reg_wr(`REG_SW_IP, 32'h9000);
    reg_wr(`REG_SW_PRCB, 32'h6000);
    reg_wr(`REG_CONTROL, 32'h1);
    wait_boot(32'h9000);
    check_load(32'h6000, 32'h3000);
    @(posedge i_clk);
    i_post_prio <= 32'h00F00000;
    i_post_irq <= 32'h00000020;
    i_post_req <= 1'b1;
    @(posedge i_clk);
    i_post_req <= 1'b0;
    #1 check("post_busy", 32'h1, {31'h0, o_post_busy});
    for (int n = 0; n < 100 && o_post_busy !== 1'b0; n++) @(posedge i_clk) #1;
    check("pend_prio", 32'h00F00000, mem_model.mem[32'h4800 + `INT_PEND_PRIO_OFF]);
    check("pend_irq", 32'h00000020, mem_model.mem[32'h4800 + `INT_PEND_IRQ_OFF]);
    conclude();
  end
endmodule

// ===== ctl_loader_params.svh
// constants for the control table loader: offsets, field positions, reset values
// assumes 32-bit byte addressing on the boot memory side
`ifndef CTL_LOADER_PARAMS_SVH
`define CTL_LOADER_PARAMS_SVH

// -------------------------------------------------------------
// process control block word offsets
// -------------------------------------------------------------
`define PRCB_FAULT_OFF 8'h00
`define PRCB_CTRL_OFF 8'h04
`define PRCB_INT_OFF 8'h10
`define PRCB_SYSPROC_OFF 8'h14

// -------------------------------------------------------------
// control table word offsets
// -------------------------------------------------------------
`define TBL_INT_MAP0_OFF 8'h10
`define TBL_INT_MAP1_OFF 8'h14
`define TBL_INT_MAP2_OFF 8'h18
`define TBL_ICFG_OFF 8'h1C
`define TBL_REGION_FIRST 8'h20
`define TBL_REGION_STRIDE 8'h08
`define TBL_TRACE_OFF 8'h68
`define TBL_BUSCFG_OFF 8'h6C
`define NUM_CTL_WORDS 14
`define NUM_PTR_WORDS 4
`define LAST_PRCB_STEP 5'h03
`define LAST_LOAD_STEP 5'h11
`define CTL_BUSCFG_IDX 13
`define PTR_CTRL_IDX 1
`define PTR_INT_IDX 2
`define TABLE_VALID_BIT 0

// -------------------------------------------------------------
// interrupt table pending fields
// -------------------------------------------------------------
`define INT_PEND_PRIO_OFF 32'h00000000
`define INT_PEND_IRQ_OFF 32'h00000004

// -------------------------------------------------------------
// part identifier, boundary-scan layout; values arbitrary
// -------------------------------------------------------------
`define ID_VERSION 4'h1
`define ID_PART 16'h5A5A
`define ID_MAKER 11'h2A5

// -------------------------------------------------------------
// register port word offsets
// -------------------------------------------------------------
`define REG_PART_ID 8'h00
`define REG_STATUS 8'h04
`define REG_CONTROL 8'h08
`define REG_SW_IP 8'h0C
`define REG_SW_PRCB 8'h10
`define REG_PTR_BASE 8'h20
`define REG_CTL_BASE 8'h40
`define REG_CTL_LAST 8'h74
`define REG_RESET_VAL 32'h00000000

`endif

// ===== ctl_loader_pkg.sv
// types shared by the control table loader
// assumes the constants header is included where offsets are needed
package ctl_loader_pkg;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_PRCB  = 6'b000010,
    ST_TABLE = 6'b000100,
    ST_GR0   = 6'b001000,
    ST_RUN   = 6'b010000,
    ST_POST  = 6'b100000
  } state_type;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_type;

endpackage
